// ==== cgc_pkg.sv ====
`default_nettype none
package cgc_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [15:0] CGC_PROC_CLOCK_CONTROL_ADDR = 16'hFFFB;
  localparam logic [7:0] CGC_PROC_CLOCK_CONTROL_RESET = 8'h04;
  localparam logic [7:0] CGC_UNMAPPED_READ = 8'h00;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int CGC_BIT_MAIN_OSC_STOP = 7;
  localparam int CGC_BIT_SUB_FEEDBACK_DISABLE = 6;
  localparam int CGC_BIT_CPU_CLOCK_STATUS = 5;
  localparam int CGC_BIT_CLOCK_SOURCE_SELECT = 4;
  localparam int CGC_BIT_ZERO = 3;
  localparam int CGC_DIV_LSB = 0;
  localparam int CGC_DIV_W = 3;

  // Bits that software can actually change
  localparam logic [7:0] CGC_WRITE_MASK = 8'hD7;

  // ----------------------------------------------------------------------
  // Divider codes and timing
  // ----------------------------------------------------------------------
  localparam logic [2:0] CGC_DIV_BY_1 = 3'h0;
  localparam logic [2:0] CGC_DIV_BY_16 = 3'h4;
  localparam logic [2:0] CGC_SUB_DIV_CODE = 3'h1;
  localparam logic [2:0] CGC_DIV_RESET = 3'h4;
  localparam int CGC_DIV_CNT_W = 4;
  // Last CPU clock phase of the two-clock fastest instruction
  localparam logic [0:0] CGC_INSTR_LAST_PHASE = 1'h1;
  // Instructions still run on the old clock after a source or divider write
  localparam logic [2:0] CGC_SWITCH_DELAY_INSTR = 3'h4;

  // ----------------------------------------------------------------------
  // Switchover sequencer
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    CGC_SW_IDLE = 2'b00,
    CGC_SW_HOLD = 2'b01,
    CGC_SW_ALIGN = 2'b11
  } cgc_switch_e;

endpackage
`default_nettype wire

// ==== cgc_sync2.sv ====
`timescale 1ns/1ps
`default_nettype none
// Two-flop synchroniser for oscillator pins sampled on sys_clk
module cgc_sync2 (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic async_in,
  output logic sync_out
);

  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;

  // ----------------------------------------------------------------------
  // Next values
  // ----------------------------------------------------------------------
  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  // Only the second flop is visible outside
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;

endmodule
`default_nettype wire

// ==== cgc_pulse_div.sv ====
`timescale 1ns/1ps
`default_nettype none
// Divides a stream of source-edge pulses by 2**sel, at most by 16
module cgc_pulse_div (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clr,
  input wire logic pulse_in,
  input wire logic [2:0] sel,
  output logic tick
);

  logic [cgc_pkg::CGC_DIV_CNT_W-1:0] cnt_q;
  logic [cgc_pkg::CGC_DIV_CNT_W-1:0] cnt_d;
  logic [cgc_pkg::CGC_DIV_CNT_W-1:0] mask;

  // ----------------------------------------------------------------------
  // Terminal count and next count
  // ----------------------------------------------------------------------
  always_comb begin
    // Codes above divide-by-16 saturate so a bad setting cannot stall the CPU
    if (sel > cgc_pkg::CGC_DIV_BY_16) begin
      mask = {cgc_pkg::CGC_DIV_CNT_W{1'b1}};
    end else begin
      mask = cgc_pkg::CGC_DIV_CNT_W'((5'h01 << sel) - 5'h01);
    end
    tick = pulse_in && ((cnt_q & mask) == mask);
    cnt_d = cnt_q;
    if (clr) begin
      cnt_d = '0;
    end else if (pulse_in) begin
      cnt_d = cnt_q + cgc_pkg::CGC_DIV_CNT_W'(1'b1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule
`default_nettype wire

// ==== cgc_clock_control.sv ====
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Reset loads control register with 04H
// - Divider codes select main/2^n or sub/2
// - Oscillation control bit one stops main oscillator
// - Feedback control bit one disconnects sub resistor
// - Bit 5 read-only, shows active CPU source
// - Register accepts bit and byte writes
// - Main stopped pulls second oscillator pin up
// - Stop instruction or control bit stops main
// - Subsystem oscillator never halted by control
// - Fastest instruction takes two CPU clocks
// - Main keeps running until CPU on subsystem
// - Switchover waits several instructions after write
// - Main oscillation stopped while reset held
module cgc_clock_control (
  input wire logic sys_clk,
  input wire logic rst,
  // CPU access to the control register
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr_byte,
  input wire logic reg_wr_bit,
  input wire logic [2:0] reg_bit_sel,
  input wire logic reg_bit_val,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Standby request from the CPU while it executes the stop instruction
  input wire logic stop_mode,
  // Oscillator pins, asynchronous to sys_clk
  input wire logic main_osc_in,
  input wire logic sub_osc_in,
  // Oscillator control
  output logic main_osc_enable,
  output logic main_osc_out_pullup,
  output logic sub_osc_enable,
  output logic sub_feedback_enable,
  // Clock enables for the CPU and peripherals, and the CPU clock status
  output logic cpu_clk_tick,
  output logic instr_tick,
  output logic periph_clk_tick,
  output logic cpu_clock_status
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic main_osc_stop_q;
  logic main_osc_stop_d;
  logic sub_feedback_disable_q;
  logic sub_feedback_disable_d;
  logic clock_source_select_q;
  logic clock_source_select_d;
  logic [2:0] div_sel_q;
  logic [2:0] div_sel_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  logic act_css_q;
  logic act_css_d;
  logic [2:0] act_div_q;
  logic [2:0] act_div_d;
  cgc_pkg::cgc_switch_e sw_state_q;
  cgc_pkg::cgc_switch_e sw_state_d;
  logic [2:0] sw_cnt_q;
  logic [2:0] sw_cnt_d;
  logic phase_q;
  logic phase_d;

  logic main_run_q;
  logic main_run_d;
  logic main_lvl_q;
  logic main_lvl_d;
  logic sub_lvl_q;
  logic sub_lvl_d;
  logic cpu_tick_q;
  logic cpu_tick_d;
  logic instr_tick_q;
  logic instr_tick_d;
  logic periph_tick_q;
  logic periph_tick_d;

  logic main_sync;
  logic sub_sync;
  logic main_edge;
  logic sub_edge;
  logic main_div_tick;
  logic sub_div_tick;
  logic cpu_tick_raw;
  logic instr_done;
  logic swap;
  logic addr_hit;
  logic wr_any;
  logic [7:0] reg_view;
  logic [7:0] wr_merged;
  logic target_differs;

  // ----------------------------------------------------------------------
  // Oscillator pin sampling
  // ----------------------------------------------------------------------
  cgc_sync2 u_sync_main (
    .sys_clk(sys_clk),
    .rst(rst),
    .async_in(main_osc_in),
    .sync_out(main_sync)
  );

  cgc_sync2 u_sync_sub (
    .sys_clk(sys_clk),
    .rst(rst),
    .async_in(sub_osc_in),
    .sync_out(sub_sync)
  );

  // Rising edges; main edges are ignored while the oscillator is stopped
  assign main_edge = main_sync && !main_lvl_q && main_run_q;
  assign sub_edge = sub_sync && !sub_lvl_q;

  // ----------------------------------------------------------------------
  // Clock dividers
  // ----------------------------------------------------------------------
  // Both dividers restart at a swap so the first new period is whole
  cgc_pulse_div u_main_div (
    .sys_clk(sys_clk),
    .rst(rst),
    .clr(swap),
    .pulse_in(main_edge),
    .sel(act_div_q),
    .tick(main_div_tick)
  );

  cgc_pulse_div u_sub_div (
    .sys_clk(sys_clk),
    .rst(rst),
    .clr(swap),
    .pulse_in(sub_edge),
    .sel(cgc_pkg::CGC_SUB_DIV_CODE),
    .tick(sub_div_tick)
  );

  // Divider code is ignored while the subsystem clock drives the CPU
  assign cpu_tick_raw = act_css_q ? sub_div_tick : main_div_tick;
  assign instr_done = cpu_tick_raw && (phase_q == cgc_pkg::CGC_INSTR_LAST_PHASE);

  // ----------------------------------------------------------------------
  // Register access decode
  // ----------------------------------------------------------------------
  assign addr_hit = (reg_addr == cgc_pkg::CGC_PROC_CLOCK_CONTROL_ADDR);
  assign wr_any = addr_hit && (reg_wr_byte || reg_wr_bit);

  // Status bit shows the source actually clocking the CPU, bit 3 reads zero
  always_comb begin
    reg_view = '0;
    reg_view[cgc_pkg::CGC_BIT_MAIN_OSC_STOP] = main_osc_stop_q;
    reg_view[cgc_pkg::CGC_BIT_SUB_FEEDBACK_DISABLE] = sub_feedback_disable_q;
    reg_view[cgc_pkg::CGC_BIT_CPU_CLOCK_STATUS] = act_css_q;
    reg_view[cgc_pkg::CGC_BIT_CLOCK_SOURCE_SELECT] = clock_source_select_q;
    reg_view[cgc_pkg::CGC_DIV_LSB +: cgc_pkg::CGC_DIV_W] = div_sel_q;
  end

  // A bit write is a read-modify-write of the whole byte
  always_comb begin
    wr_merged = reg_view;
    if (reg_wr_byte) begin
      wr_merged = reg_wdata;
    end else if (reg_wr_bit) begin
      wr_merged[reg_bit_sel] = reg_bit_val;
    end
  end

  // ----------------------------------------------------------------------
  // Control register next values
  // ----------------------------------------------------------------------
  always_comb begin
    main_osc_stop_d = main_osc_stop_q;
    sub_feedback_disable_d = sub_feedback_disable_q;
    clock_source_select_d = clock_source_select_q;
    div_sel_d = div_sel_q;
    rdata_d = rdata_q;
    // Status bit and bit 3 are outside the write mask and never stored
    if (wr_any) begin
      main_osc_stop_d = wr_merged[cgc_pkg::CGC_BIT_MAIN_OSC_STOP] &
                        cgc_pkg::CGC_WRITE_MASK[cgc_pkg::CGC_BIT_MAIN_OSC_STOP];
      sub_feedback_disable_d = wr_merged[cgc_pkg::CGC_BIT_SUB_FEEDBACK_DISABLE] &
                               cgc_pkg::CGC_WRITE_MASK[cgc_pkg::CGC_BIT_SUB_FEEDBACK_DISABLE];
      clock_source_select_d = wr_merged[cgc_pkg::CGC_BIT_CLOCK_SOURCE_SELECT] &
                              cgc_pkg::CGC_WRITE_MASK[cgc_pkg::CGC_BIT_CLOCK_SOURCE_SELECT];
      div_sel_d = wr_merged[cgc_pkg::CGC_DIV_LSB +: cgc_pkg::CGC_DIV_W];
    end
    if (reg_rd) begin
      rdata_d = addr_hit ? reg_view : cgc_pkg::CGC_UNMAPPED_READ;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      main_osc_stop_q <= cgc_pkg::CGC_PROC_CLOCK_CONTROL_RESET[cgc_pkg::CGC_BIT_MAIN_OSC_STOP];
      sub_feedback_disable_q <= cgc_pkg::CGC_PROC_CLOCK_CONTROL_RESET[cgc_pkg::CGC_BIT_SUB_FEEDBACK_DISABLE];
      clock_source_select_q <= cgc_pkg::CGC_PROC_CLOCK_CONTROL_RESET[cgc_pkg::CGC_BIT_CLOCK_SOURCE_SELECT];
      div_sel_q <= cgc_pkg::CGC_PROC_CLOCK_CONTROL_RESET[cgc_pkg::CGC_DIV_LSB +: cgc_pkg::CGC_DIV_W];
      rdata_q <= cgc_pkg::CGC_UNMAPPED_READ;
    end else begin
      main_osc_stop_q <= main_osc_stop_d;
      sub_feedback_disable_q <= sub_feedback_disable_d;
      clock_source_select_q <= clock_source_select_d;
      div_sel_q <= div_sel_d;
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------------------------------------
  // Switchover sequencer
  // ----------------------------------------------------------------------
  // Compare against the freshly written value so a write starts the hold
  assign target_differs = (clock_source_select_d != act_css_q) ||
                          (!clock_source_select_d && (div_sel_d != act_div_q));
  // Swap lands on a tick of the old clock, so no shortened CPU period
  assign swap = (sw_state_q == cgc_pkg::CGC_SW_ALIGN) && cpu_tick_raw && target_differs;

  always_comb begin
    sw_state_d = sw_state_q;
    sw_cnt_d = sw_cnt_q;
    act_css_d = act_css_q;
    act_div_d = act_div_q;
    phase_d = phase_q;
    if (cpu_tick_raw) begin
      phase_d = ~phase_q;
    end
    unique case (sw_state_q)
      cgc_pkg::CGC_SW_IDLE: begin
        if (wr_any && target_differs) begin
          sw_state_d = cgc_pkg::CGC_SW_HOLD;
          sw_cnt_d = '0;
        end
      end
      cgc_pkg::CGC_SW_HOLD: begin
        // Old clock keeps running for a few instructions
        if (!target_differs) begin
          sw_state_d = cgc_pkg::CGC_SW_IDLE;
        end else if (wr_any) begin
          sw_cnt_d = '0;
        end else if (instr_done) begin
          if (sw_cnt_q == cgc_pkg::CGC_SWITCH_DELAY_INSTR - 3'h1) begin
            sw_state_d = cgc_pkg::CGC_SW_ALIGN;
          end else begin
            sw_cnt_d = sw_cnt_q + 3'h1;
          end
        end
      end
      cgc_pkg::CGC_SW_ALIGN: begin
        if (!target_differs) begin
          sw_state_d = cgc_pkg::CGC_SW_IDLE;
        end else if (swap) begin
          act_css_d = clock_source_select_d;
          act_div_d = div_sel_d;
          phase_d = 1'b0;
          sw_state_d = cgc_pkg::CGC_SW_IDLE;
        end
      end
      default: begin
        sw_state_d = cgc_pkg::CGC_SW_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sw_state_q <= cgc_pkg::CGC_SW_IDLE;
      sw_cnt_q <= '0;
      act_css_q <= 1'b0;
      act_div_q <= cgc_pkg::CGC_DIV_RESET;
      phase_q <= 1'b0;
    end else begin
      sw_state_q <= sw_state_d;
      sw_cnt_q <= sw_cnt_d;
      act_css_q <= act_css_d;
      act_div_q <= act_div_d;
      phase_q <= phase_d;
    end
  end

  // ----------------------------------------------------------------------
  // Oscillator control and clock enables
  // ----------------------------------------------------------------------
  // Stop bit only bites once the CPU really runs on the subsystem clock
  always_comb begin
    main_run_d = !stop_mode && !(main_osc_stop_q && act_css_q);
    main_lvl_d = main_sync;
    sub_lvl_d = sub_sync;
    cpu_tick_d = cpu_tick_raw;
    instr_tick_d = instr_done;
    // Peripherals run on the undivided main clock
    periph_tick_d = main_edge;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      main_run_q <= 1'b0;
      main_lvl_q <= 1'b0;
      sub_lvl_q <= 1'b0;
      cpu_tick_q <= 1'b0;
      instr_tick_q <= 1'b0;
      periph_tick_q <= 1'b0;
    end else begin
      main_run_q <= main_run_d;
      main_lvl_q <= main_lvl_d;
      sub_lvl_q <= sub_lvl_d;
      cpu_tick_q <= cpu_tick_d;
      instr_tick_q <= instr_tick_d;
      periph_tick_q <= periph_tick_d;
    end
  end

  // Outputs
  assign main_osc_enable = main_run_q;
  assign main_osc_out_pullup = !main_run_q;
  assign sub_osc_enable = 1'b1;
  assign sub_feedback_enable = !sub_feedback_disable_q;
  assign cpu_clk_tick = cpu_tick_q;
  assign instr_tick = instr_tick_q;
  assign periph_clk_tick = periph_tick_q;
  assign cpu_clock_status = act_css_q;
  assign reg_rdata = rdata_q;

endmodule
`default_nettype wire

// ==== cgc_osc_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// --------------------------------
// Resonator pair behind the oscillator pins
// --------------------------------
module cgc_osc_model #(
  parameter real MAIN_HALF_NS = 20.0,
  parameter real SUB_HALF_NS = 50.0,
  parameter real START_NS = 1.3
) (
  input wire logic main_osc_enable,
  output logic main_osc_in,
  output logic sub_osc_in
);
  // Main resonator: a stopped crystal settles low, so stale edges never leak
  initial begin
    main_osc_in = 1'b0;
    #(START_NS);
    forever begin
      #(MAIN_HALF_NS);
      if (main_osc_enable === 1'b1) begin
        main_osc_in = !main_osc_in;
      end else begin
        main_osc_in = 1'b0;
      end
    end
  end

  // Subsystem crystal never stops; phase unrelated to sys_clk
  initial begin
    sub_osc_in = 1'b0;
    forever begin
      #(SUB_HALF_NS);
      sub_osc_in = !sub_osc_in;
    end
  end
endmodule
`default_nettype wire

// ==== cgc_clock_control_props.sv ====
`timescale 1ns/1ps
`default_nettype none
// --------------------------------
// Port checker
// --------------------------------
module cgc_clock_control_props (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr_byte,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic stop_mode,
  input wire logic main_osc_enable,
  input wire logic main_osc_out_pullup,
  input wire logic sub_osc_enable,
  input wire logic sub_feedback_enable,
  input wire logic cpu_clk_tick,
  input wire logic instr_tick,
  input wire logic cpu_clock_status
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic wr_hit;
  logic rd_hit;
  // Mapped accesses only; unmapped ones must not move the register
  assign wr_hit = reg_wr_byte && (reg_addr == cgc_pkg::CGC_PROC_CLOCK_CONTROL_ADDR);
  assign rd_hit = reg_rd && (reg_addr == cgc_pkg::CGC_PROC_CLOCK_CONTROL_ADDR);

  chk_pullup_mirror: assert property (main_osc_out_pullup == !main_osc_enable)
    else $error("pull-up does not mirror stopped main oscillator");
  chk_reset_stop: assert property (disable iff (1'b0) rst |=> !main_osc_enable)
    else $error("main oscillator runs during reset");
  chk_sub_running: assert property (sub_osc_enable)
    else $error("subsystem oscillator halted");
  chk_feedback_write: assert property (wr_hit |=> sub_feedback_enable == !$past(reg_wdata[6]))
    else $error("feedback enable does not follow written bit");
  chk_stop_instr: assert property (stop_mode |=> !main_osc_enable)
    else $error("main oscillator runs in stop mode");
  chk_main_hold: assert property (!stop_mode && !cpu_clock_status |=> main_osc_enable)
    else $error("main oscillator stopped while cpu on main");
  chk_instr_pace: assert property (instr_tick |-> cpu_clk_tick)
    else $error("instruction end off a cpu clock");
  chk_status_read: assert property (rd_hit |=> (reg_rdata[5] == cpu_clock_status) ||
    (reg_rdata[5] == $past(cpu_clock_status)))
    else $error("status bit read back wrong");
  chk_zero_bit: assert property (rd_hit |=> !reg_rdata[3])
    else $error("bit 3 reads one");

  cover property ($rose(cpu_clock_status));
  cover property (stop_mode ##1 !main_osc_enable);
  cover property (wr_hit ##1 !sub_feedback_enable);
endmodule

bind cgc_clock_control cgc_clock_control_props i_cgc_clock_control_props (
  .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr_byte(reg_wr_byte),
  .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .stop_mode(stop_mode),
  .main_osc_enable(main_osc_enable), .main_osc_out_pullup(main_osc_out_pullup),
  .sub_osc_enable(sub_osc_enable), .sub_feedback_enable(sub_feedback_enable),
  .cpu_clk_tick(cpu_clk_tick), .instr_tick(instr_tick), .cpu_clock_status(cpu_clock_status)
);
`default_nettype wire

// ==== cgc_clock_control_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
// --------------------------------
// Self-checking bench
// --------------------------------
module cgc_clock_control_bench;
  localparam logic [15:0] ADDR = cgc_pkg::CGC_PROC_CLOCK_CONTROL_ADDR;
  localparam int MAIN_CYC = 8;
  localparam int SUB_CPU_CYC = 40;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] reg_addr = 16'h0000;
  logic reg_wr_byte = 1'b0;
  logic reg_wr_bit = 1'b0;
  logic [2:0] reg_bit_sel = 3'h0;
  logic reg_bit_val = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_rd = 1'b0;
  logic stop_mode = 1'b0;
  logic [7:0] reg_rdata;
  logic main_osc_in, sub_osc_in, main_osc_enable, main_osc_out_pullup, sub_osc_enable;
  logic sub_feedback_enable, cpu_clk_tick, instr_tick, periph_clk_tick, cpu_clock_status;
  int fail_count = 0;
  int check_count = 0;

  // 200 MHz system clock
  always #2.5 sys_clk = ~sys_clk;

  cgc_clock_control i_cgc_clock_control (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wr_byte(reg_wr_byte), .reg_wr_bit(reg_wr_bit), .reg_bit_sel(reg_bit_sel),
    .reg_bit_val(reg_bit_val), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .stop_mode(stop_mode), .main_osc_in(main_osc_in), .sub_osc_in(sub_osc_in),
    .main_osc_enable(main_osc_enable), .main_osc_out_pullup(main_osc_out_pullup),
    .sub_osc_enable(sub_osc_enable), .sub_feedback_enable(sub_feedback_enable),
    .cpu_clk_tick(cpu_clk_tick), .instr_tick(instr_tick), .periph_clk_tick(periph_clk_tick),
    .cpu_clock_status(cpu_clock_status));
  cgc_osc_model i_cgc_osc_model (.main_osc_enable(main_osc_enable), .main_osc_in(main_osc_in),
    .sub_osc_in(sub_osc_in));

  // --------------------------------
  // Reporting and comparison
  // --------------------------------
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    cmp_byte({7'h00, got}, {7'h00, exp});
  endtask
  task automatic cmp_count(input int got, input int exp);
    check_count++;
    if (got != exp) begin
      fail_count++;
      $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  // A bound ran out: the design hung, so stop here
  task automatic give_up();
    fail_count++;
    $display("ERROR at %0t: wait bound used up, got 0 expected 1", $time);
    summarize();
  endtask

  // --------------------------------
  // Register access and waits
  // --------------------------------
  task automatic wr_byte(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr_byte <= 1'b1;
    @(posedge sys_clk);
    reg_wr_byte <= 1'b0;
  endtask
  task automatic wr_bit(input logic [2:0] s, input logic v);
    @(posedge sys_clk);
    reg_addr <= ADDR;
    reg_bit_sel <= s;
    reg_bit_val <= v;
    reg_wr_bit <= 1'b1;
    @(posedge sys_clk);
    reg_wr_bit <= 1'b0;
  endtask
  // Read data is checked in the very cycle after the strobe is taken
  task automatic rd_check(input logic [15:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    cmp_byte(reg_rdata, exp);
  endtask
  task automatic tick_gap(input bit use_instr, output int g);
    int first;
    first = -1;
    g = -1;
    for (int n = 0; n < 6000 && g < 0; n++) begin
      @(posedge sys_clk);
      #1;
      if ((use_instr ? instr_tick : cpu_clk_tick) === 1'b1) begin
        if (first >= 0) g = n - first;
        first = n;
      end
    end
    if (g < 0) give_up();
  endtask
  task automatic skip_cpu(input int k);
    int seen;
    seen = 0;
    for (int n = 0; n < 20000 && seen < k; n++) begin
      @(posedge sys_clk);
      #1;
      if (cpu_clk_tick === 1'b1) seen++;
    end
    if (seen < k) give_up();
  endtask
  task automatic wait_status(input logic v);
    int n;
    for (n = 0; n < 20000 && cpu_clock_status !== v; n++) begin
      @(posedge sys_clk);
      #1;
    end
    if (n >= 20000) give_up();
  endtask
  task automatic count_periph(input int cycles, output int c);
    c = 0;
    repeat (cycles) begin
      @(posedge sys_clk);
      #1;
      if (periph_clk_tick === 1'b1) c++;
    end
  endtask

  // --------------------------------
  // Scenarios
  // --------------------------------
  task automatic t_reset_values();
    repeat (3) @(posedge sys_clk);
    #1;
    cmp_bit(main_osc_enable, 1'b1);
    cmp_bit(sub_feedback_enable, 1'b1);
    cmp_bit(sub_osc_enable, 1'b1);
    rd_check(ADDR, 8'h04);
    $display("t_reset_values done");
  endtask
  // Old rate must persist right after each write, new rate after the switch
  task automatic t_dividers();
    int g;
    int prev;
    prev = 4;
    for (int c = 0; c <= 4; c++) begin
      wr_byte(ADDR, {5'h00, 3'(c)});
      tick_gap(1'b0, g);
      cmp_count(g, MAIN_CYC << prev);
      skip_cpu(12);
      tick_gap(1'b0, g);
      cmp_count(g, MAIN_CYC << c);
      tick_gap(1'b1, g);
      cmp_count(g, 2 * (MAIN_CYC << c));
      prev = c;
    end
    $display("t_dividers done");
  endtask
  task automatic t_bits();
    wr_bit(3'h6, 1'b1);
    @(posedge sys_clk);
    #1;
    cmp_bit(sub_feedback_enable, 1'b0);
    // Deliberate bad writes to the fixed-zero and read-only bits
    wr_bit(3'h3, 1'b1);
    wr_bit(3'h5, 1'b1);
    rd_check(ADDR, 8'h44);
    wr_bit(3'h6, 1'b0);
    rd_check(ADDR, 8'h04);
    cmp_bit(sub_feedback_enable, 1'b1);
    $display("t_bits done");
  endtask
  task automatic t_stop();
    int n;
    @(posedge sys_clk);
    stop_mode <= 1'b1;
    repeat (8) @(posedge sys_clk);
    #1;
    cmp_bit(main_osc_enable, 1'b0);
    cmp_bit(main_osc_out_pullup, 1'b1);
    count_periph(64, n);
    cmp_count(n, 0);
    @(posedge sys_clk);
    stop_mode <= 1'b0;
    repeat (16) @(posedge sys_clk);
    #1;
    cmp_bit(main_osc_enable, 1'b1);
    count_periph(64, n);
    cmp_count(n, 64 / MAIN_CYC);
    $display("t_stop done");
  endtask
  task automatic t_sub_switch();
    int g;
    wr_bit(3'h7, 1'b1);
    repeat (20) @(posedge sys_clk);
    #1;
    cmp_bit(main_osc_enable, 1'b1);
    wr_byte(ADDR, 8'h94);
    rd_check(ADDR, 8'h94);
    wait_status(1'b1);
    skip_cpu(2);
    cmp_bit(main_osc_enable, 1'b0);
    cmp_bit(main_osc_out_pullup, 1'b1);
    tick_gap(1'b0, g);
    cmp_count(g, SUB_CPU_CYC);
    tick_gap(1'b1, g);
    cmp_count(g, 2 * SUB_CPU_CYC);
    count_periph(64, g);
    cmp_count(g, 0);
    rd_check(ADDR, 8'hB4);
    wr_byte(ADDR, 8'h04);
    wait_status(1'b0);
    rd_check(ADDR, 8'h04);
    cmp_bit(main_osc_enable, 1'b1);
    $display("t_sub_switch done");
  endtask
  task automatic t_unmapped();
    int g;
    // Prohibited code 5 is kept and still divides by sixteen
    wr_byte(ADDR, 8'h05);
    rd_check(ADDR, 8'h05);
    skip_cpu(12);
    tick_gap(1'b0, g);
    cmp_count(g, MAIN_CYC << 4);
    wr_byte(ADDR, 8'h04);
    skip_cpu(12);
    wr_byte(16'hFFFA, 8'hFF);
    rd_check(16'hFFFA, cgc_pkg::CGC_UNMAPPED_READ);
    rd_check(ADDR, 8'h04);
    $display("t_unmapped done");
  endtask

  // Main sequence: reset held for 12 cycles, then each scenario in turn
  initial begin
    repeat (3) @(posedge sys_clk);
    #1;
    cmp_bit(main_osc_enable, 1'b0);
    repeat (9) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset_values();
    t_dividers();
    t_bits();
    t_stop();
    t_sub_switch();
    t_unmapped();
    summarize();
  end
endmodule
`default_nettype wire
